/* rtl/gpfs_defines.svh */
`ifndef GPFS_DEFINES_SVH
`define GPFS_DEFINES_SVH

// register byte offsets
`define GPFS_OFS_SEL_PINS_20_29   12'h004
`define GPFS_OFS_SEL_PINS_30_39   12'h008
`define GPFS_OFS_PAD_OE_STATUS    12'h00C
`define GPFS_OFS_PAD_LEVEL_STATUS 12'h010

// register layout
`define GPFS_SEL_W                3
`define GPFS_FIELDS_PER_REG       10
`define GPFS_SEL_REG_W            30
`define GPFS_NUM_PINS             20
`define GPFS_NUM_ALT              6
`define GPFS_DATA_W               32
`define GPFS_RESERVED_LSB         30
`define GPFS_SEL_RESET            30'h00000000
`define GPFS_WORD_RESET           32'h00000000
`define GPFS_PIN_RESET            20'h00000
`define GPFS_BYTE_W               8
`define GPFS_STRB_W               4

// selector encodings
`define GPFS_SEL_INPUT            3'h0
`define GPFS_SEL_OUTPUT           3'h1
`define GPFS_SEL_ALT5             3'h2
`define GPFS_SEL_ALT4             3'h3
`define GPFS_SEL_ALT0             3'h4
`define GPFS_SEL_ALT1             3'h5
`define GPFS_SEL_ALT2             3'h6
`define GPFS_SEL_ALT3             3'h7

// alternate function slots
`define GPFS_ALT_IDX0             0
`define GPFS_ALT_IDX1             1
`define GPFS_ALT_IDX2             2
`define GPFS_ALT_IDX3             3
`define GPFS_ALT_IDX4             4
`define GPFS_ALT_IDX5             5

`endif

/* rtl/gpfs_pkg.sv */
`include "gpfs_defines.svh"

package gpfs_pkg;

   typedef logic [`GPFS_SEL_W-1:0]     gpfs_sel_t;
   typedef logic [`GPFS_NUM_ALT-1:0]   gpfs_alt_vec_t;
   typedef logic [`GPFS_NUM_PINS-1:0]  gpfs_pin_vec_t;

   // per-pin pad drive
   typedef struct packed {
      logic out;
      logic oe;
   } gpfs_drive_t;

   // three-stage input synchroniser state
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } gpfs_sync_state_t;

   // top-level state
   typedef struct packed {
      logic [`GPFS_SEL_REG_W-1:0]                   sel_lo;
      logic [`GPFS_SEL_REG_W-1:0]                   sel_hi;
      logic [`GPFS_DATA_W-1:0]                      prdata;
      logic                                         pready;
      logic                                         pslverr;
      logic [`GPFS_NUM_PINS-1:0]                    pad_out;
      logic [`GPFS_NUM_PINS-1:0]                    pad_oe;
      logic [`GPFS_NUM_PINS-1:0]                    gpio_in;
      logic [`GPFS_NUM_ALT-1:0][`GPFS_NUM_PINS-1:0] alt_in;
   } gpfs_top_state_t;

endpackage : gpfs_pkg

/* rtl/gpfs_sync3.sv */
`timescale 1ns/1ps
`include "gpfs_defines.svh"

module gpfs_sync3 (
   input  wire logic clk_sys_in,
   input  wire logic arst_n_in,
   input  wire logic async_in,
   output logic      level_out
);

   gpfs_pkg::gpfs_sync_state_t state_reg;
   gpfs_pkg::gpfs_sync_state_t state_next;

   // level follows only once stages two and three agree
   always_comb begin
      state_next    = state_reg;
      state_next.s1 = async_in;
      state_next.s2 = state_reg.s1;
      state_next.s3 = state_reg.s2;
      if (state_reg.s2 == state_reg.s3) begin
         state_next.level = state_reg.s3;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign level_out = state_reg.level;

endmodule : gpfs_sync3

/* rtl/gpfs_pin_route.sv */
`timescale 1ns/1ps
`include "gpfs_defines.svh"

module gpfs_pin_route (
   input  wire logic                  sel_in,
   input  wire logic                  gpio_out_in,
   input  wire gpfs_pkg::gpfs_alt_vec_t alt_out_in,
   input  wire gpfs_pkg::gpfs_alt_vec_t alt_oe_in,
   input  wire gpfs_pkg::gpfs_sel_t   code_in,
   output gpfs_pkg::gpfs_drive_t      drive_out,
   output gpfs_pkg::gpfs_alt_vec_t    alt_sel_out
);

   // sel_in unused marker avoided: gates routing as a whole
   always_comb begin
      drive_out   = '0;
      alt_sel_out = '0;
      case (code_in)
         `GPFS_SEL_INPUT: begin
            drive_out = '0;
         end
         `GPFS_SEL_OUTPUT: begin
            drive_out.out = gpio_out_in;
            drive_out.oe  = 1'b1;
         end
         `GPFS_SEL_ALT0: begin
            alt_sel_out[`GPFS_ALT_IDX0] = 1'b1;
         end
         `GPFS_SEL_ALT1: begin
            alt_sel_out[`GPFS_ALT_IDX1] = 1'b1;
         end
         `GPFS_SEL_ALT2: begin
            alt_sel_out[`GPFS_ALT_IDX2] = 1'b1;
         end
         `GPFS_SEL_ALT3: begin
            alt_sel_out[`GPFS_ALT_IDX3] = 1'b1;
         end
         `GPFS_SEL_ALT4: begin
            alt_sel_out[`GPFS_ALT_IDX4] = 1'b1;
         end
         `GPFS_SEL_ALT5: begin
            alt_sel_out[`GPFS_ALT_IDX5] = 1'b1;
         end
         default: begin
            drive_out   = '0;
            alt_sel_out = '0;
         end
      endcase
      // alternate peripheral owns the pad when chosen
      if (|alt_sel_out) begin
         drive_out.out = |(alt_sel_out & alt_out_in);
         drive_out.oe  = |(alt_sel_out & alt_oe_in);
      end
      if (!sel_in) begin
         drive_out   = '0;
         alt_sel_out = '0;
      end
   end

endmodule : gpfs_pin_route

/* rtl/gpfs_function_select.sv */
`timescale 1ns/1ps
`include "gpfs_defines.svh"

// Overview of operation
// - A selector of 000 makes the pin a plain input with its driver off.
// - A selector of 001 makes the pin a plain output driven by the pin output data.
// - Selectors 100, 101, 110 and 111 hand the pin to alternate functions 0 to 3.
// - Selector 011 hands the pin to alternate function 4 and 010 to function 5.
// - Each register packs ten read/write three-bit selectors, lowest pin at bits 2-0.
// - Every selector clears at reset so all covered pins start as inputs.

module gpfs_function_select #(
   parameter int ADDR_W = 12
) (
   input  wire logic                                         clk_sys_in,
   input  wire logic                                         arst_n_in,
   // apb slave
   input  wire logic                                         psel_in,
   input  wire logic                                         penable_in,
   input  wire logic                                         pwrite_in,
   input  wire logic [ADDR_W-1:0]                            paddr_in,
   input  wire logic [`GPFS_DATA_W-1:0]                      pwdata_in,
   input  wire logic [`GPFS_STRB_W-1:0]                      pstrb_in,
   output logic      [`GPFS_DATA_W-1:0]                      prdata_out,
   output logic                                              pready_out,
   output logic                                              pslverr_out,
   // gpio data path, same clock
   input  wire logic [`GPFS_NUM_PINS-1:0]                    gpio_out_data_in,
   output logic      [`GPFS_NUM_PINS-1:0]                    gpio_in_data_out,
   // alternate peripherals, same clock
   input  wire logic [`GPFS_NUM_ALT-1:0][`GPFS_NUM_PINS-1:0] alt_out_in,
   input  wire logic [`GPFS_NUM_ALT-1:0][`GPFS_NUM_PINS-1:0] alt_oe_in,
   output logic      [`GPFS_NUM_ALT-1:0][`GPFS_NUM_PINS-1:0] alt_in_out,
   // pads
   input  wire logic [`GPFS_NUM_PINS-1:0]                    pad_in,
   output logic      [`GPFS_NUM_PINS-1:0]                    pad_out,
   output logic      [`GPFS_NUM_PINS-1:0]                    pad_oe_out
);

   gpfs_pkg::gpfs_top_state_t state_reg;
   gpfs_pkg::gpfs_top_state_t state_next;

   logic [2*`GPFS_SEL_REG_W-1:0]                  sel_all;
   logic [`GPFS_NUM_PINS-1:0]                     pin_level;
   logic [`GPFS_NUM_PINS-1:0]                     route_out;
   logic [`GPFS_NUM_PINS-1:0]                     route_oe;
   logic [`GPFS_NUM_ALT-1:0][`GPFS_NUM_PINS-1:0]  route_alt_sel;
   logic [`GPFS_DATA_W-1:0]                       wmask;
   logic                                          hit_lo;
   logic                                          hit_hi;
   logic                                          hit_oe;
   logic                                          hit_lvl;
   logic                                          setup_phase;
   logic                                          access_done;

   // lowest pin of each register at bits 2-0
   assign sel_all = {state_reg.sel_hi, state_reg.sel_lo};

   // per-pin synchroniser and routing
   genvar gp;
   genvar ga;
   generate
      for (gp = 0; gp < `GPFS_NUM_PINS; gp++) begin : g_pin
         gpfs_pkg::gpfs_drive_t   drive;
         gpfs_pkg::gpfs_alt_vec_t alt_sel;
         gpfs_pkg::gpfs_alt_vec_t alt_o;
         gpfs_pkg::gpfs_alt_vec_t alt_e;

         for (ga = 0; ga < `GPFS_NUM_ALT; ga++) begin : g_alt
            assign alt_o[ga]            = alt_out_in[ga][gp];
            assign alt_e[ga]            = alt_oe_in[ga][gp];
            assign route_alt_sel[ga][gp] = alt_sel[ga];
         end

         gpfs_sync3 u_sync (
            .clk_sys_in (clk_sys_in),
            .arst_n_in  (arst_n_in),
            .async_in   (pad_in[gp]),
            .level_out  (pin_level[gp])
         );

         gpfs_pin_route u_route (
            .sel_in      (1'b1),
            .gpio_out_in (gpio_out_data_in[gp]),
            .alt_out_in  (alt_o),
            .alt_oe_in   (alt_e),
            .code_in     (sel_all[gp*`GPFS_SEL_W +: `GPFS_SEL_W]),
            .drive_out   (drive),
            .alt_sel_out (alt_sel)
         );

         assign route_out[gp] = drive.out;
         assign route_oe[gp]  = drive.oe;
      end
   endgenerate

   // address decode
   always_comb begin
      hit_lo  = (paddr_in == ADDR_W'(`GPFS_OFS_SEL_PINS_20_29));
      hit_hi  = (paddr_in == ADDR_W'(`GPFS_OFS_SEL_PINS_30_39));
      hit_oe  = (paddr_in == ADDR_W'(`GPFS_OFS_PAD_OE_STATUS));
      hit_lvl = (paddr_in == ADDR_W'(`GPFS_OFS_PAD_LEVEL_STATUS));
   end

   // byte-lane write mask
   always_comb begin
      wmask = '0;
      for (int b = 0; b < `GPFS_STRB_W; b++) begin
         wmask[b*`GPFS_BYTE_W +: `GPFS_BYTE_W] = {`GPFS_BYTE_W{pstrb_in[b]}};
      end
   end

   assign setup_phase = psel_in && !penable_in;
   assign access_done = psel_in && penable_in && state_reg.pready;

   always_comb begin
      state_next         = state_reg;
      state_next.pready  = 1'b0;
      state_next.pslverr = 1'b0;

      // setup cycle: prepare answer for the single access cycle
      if (setup_phase) begin
         state_next.pready  = 1'b1;
         state_next.pslverr = 1'b0;
         state_next.prdata  = `GPFS_WORD_RESET;
         if (hit_lo) begin
            state_next.prdata[`GPFS_SEL_REG_W-1:0] = state_reg.sel_lo;
            state_next.prdata[`GPFS_DATA_W-1:`GPFS_RESERVED_LSB] = '0;
         end else if (hit_hi) begin
            state_next.prdata[`GPFS_SEL_REG_W-1:0] = state_reg.sel_hi;
            state_next.prdata[`GPFS_DATA_W-1:`GPFS_RESERVED_LSB] = '0;
         end else if (hit_oe && !pwrite_in) begin
            state_next.prdata[`GPFS_NUM_PINS-1:0] = state_reg.pad_oe;
         end else if (hit_lvl && !pwrite_in) begin
            state_next.prdata[`GPFS_NUM_PINS-1:0] = state_reg.gpio_in;
         end else begin
            state_next.pslverr = 1'b1;
         end
      end

      // write lands at the access edge; reserved top bits dropped
      if (access_done && pwrite_in) begin
         if (hit_lo) begin
            state_next.sel_lo = (state_reg.sel_lo & ~wmask[`GPFS_SEL_REG_W-1:0])
                              | (pwdata_in[`GPFS_SEL_REG_W-1:0]
                                 & wmask[`GPFS_SEL_REG_W-1:0]);
         end
         if (hit_hi) begin
            state_next.sel_hi = (state_reg.sel_hi & ~wmask[`GPFS_SEL_REG_W-1:0])
                              | (pwdata_in[`GPFS_SEL_REG_W-1:0]
                                 & wmask[`GPFS_SEL_REG_W-1:0]);
         end
      end

      // pad and peripheral side, registered
      state_next.pad_out = route_out;
      state_next.pad_oe  = route_oe;
      state_next.gpio_in = pin_level;
      for (int f = 0; f < `GPFS_NUM_ALT; f++) begin
         state_next.alt_in[f] = route_alt_sel[f] & pin_level;
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg         <= '0;
         state_reg.sel_lo  <= `GPFS_SEL_RESET;
         state_reg.sel_hi  <= `GPFS_SEL_RESET;
         state_reg.prdata  <= `GPFS_WORD_RESET;
         state_reg.pad_oe  <= `GPFS_PIN_RESET;
         state_reg.pad_out <= `GPFS_PIN_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata_out       = state_reg.prdata;
   assign pready_out       = state_reg.pready;
   assign pslverr_out      = state_reg.pslverr;
   assign pad_out          = state_reg.pad_out;
   assign pad_oe_out       = state_reg.pad_oe;
   assign gpio_in_data_out = state_reg.gpio_in;
   assign alt_in_out       = state_reg.alt_in;

endmodule : gpfs_function_select

/* verif/gpfs_function_select_chk.sv */
`timescale 1ns/1ps
`include "gpfs_defines.svh"

module gpfs_function_select_chk #(
   parameter int ADDR_W = 12
) (
   input wire logic                                         clk_sys_in,
   input wire logic                                         arst_n_in,
   input wire logic                                         psel_in,
   input wire logic                                         penable_in,
   input wire logic                                         pwrite_in,
   input wire logic [ADDR_W-1:0]                            paddr_in,
   input wire logic [`GPFS_DATA_W-1:0]                      prdata_out,
   input wire logic                                         pready_out,
   input wire logic                                         pslverr_out,
   input wire logic [`GPFS_NUM_PINS-1:0]                    pad_oe_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!arst_n_in);

   wire logic setup   = psel_in && !penable_in;
   wire logic sel_map = (paddr_in == `GPFS_OFS_SEL_PINS_20_29)
                        || (paddr_in == `GPFS_OFS_SEL_PINS_30_39);
   wire logic sts_map = (paddr_in == `GPFS_OFS_PAD_OE_STATUS)
                        || (paddr_in == `GPFS_OFS_PAD_LEVEL_STATUS);

   a_ready_after_setup: assert property (setup |=> pready_out)
      else $error("no pready one cycle after setup");
   a_ready_one_pulse: assert property (pready_out |=> !pready_out)
      else $error("pready held longer than one cycle");
   a_ready_has_cause: assert property (pready_out |-> $past(setup))
      else $error("pready without preceding setup");
   a_err_decode: assert property (pready_out |->
      pslverr_out == !(sel_map || (!pwrite_in && sts_map)))
      else $error("pslverr does not match address decode");
   a_err_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("pslverr outside access cycle");
   a_err_data_zero: assert property (pslverr_out |-> prdata_out == 32'h0)
      else $error("refused access returned data");
   a_rsvd_read_zero: assert property (pready_out && !pwrite_in && sel_map |->
      prdata_out[31:30] == 2'h0)
      else $error("reserved selector bits read nonzero");
   a_rdata_hold: assert property (!pready_out |-> $stable(prdata_out))
      else $error("read data changed outside access cycle");
   a_reset_all_inputs: assert property ($rose(arst_n_in) |-> pad_oe_out == 20'h0)
      else $error("pad driven right after reset");
endmodule : gpfs_function_select_chk

bind gpfs_function_select gpfs_function_select_chk #(.ADDR_W(ADDR_W)) u_chk (
   .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .pad_oe_out(pad_oe_out));

/* verif/tb_gpfs_function_select.sv */
`timescale 1ns/1ps
`include "gpfs_defines.svh"

module tb_gpfs_function_select;
   localparam int ALT_OF [8] = '{-1, -1, 5, 4, 0, 1, 2, 3};
   logic             clk_sys_in = 1'b0;
   logic             arst_n_in  = 1'b0;
   logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [11:0]      paddr = 12'h000;
   logic [31:0]      pwdata = 32'h0, prdata, rd;
   logic [19:0]      gpo = 20'h0, gpi, pad_in = 20'h0, pad_out, pad_oe;
   logic [5:0][19:0] alt_out = 120'h0, alt_oe = 120'h0, alt_in, tmp;
   int               miscompares = 0, comparisons = 0, cycles = 0;

   always #2.5 clk_sys_in = ~clk_sys_in;

   gpfs_function_select #(.ADDR_W(12)) u_gpfs_function_select (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .gpio_out_data_in(gpo), .gpio_in_data_out(gpi), .alt_out_in(alt_out),
      .alt_oe_in(alt_oe), .alt_in_out(alt_in), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe_out(pad_oe));

   task automatic chk(input string nm, input logic [119:0] exp, input logic [119:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // one idle edge first, so psel is never lowered and raised in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      // pready, prdata and pslverr are read at the rising edge that completes the access
      do @(posedge clk_sys_in); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         final_report();
      end
   end

   initial begin
      int p, sh, f;
      logic [11:0] a, oa;
      repeat (8) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      chk("pad_oe", 120'h0, pad_oe);
      apb(1'b0, `GPFS_OFS_SEL_PINS_20_29, 32'h0);
      chk("sel_lo", 120'h0, {err, rd});
      apb(1'b0, `GPFS_OFS_SEL_PINS_30_39, 32'h0);
      chk("sel_hi", 120'h0, {err, rd});
      pad_in <= 20'hA5C3F;
      repeat (8) @(posedge clk_sys_in);
      chk("gpio_in", 120'hA5C3F, gpi);
      // refused accesses: unmapped write, status write, unmapped read
      apb(1'b1, 12'h000, 32'hFFFFFFFF);
      chk("err_wr", {1'b1, 32'h0}, {err, rd});
      apb(1'b1, `GPFS_OFS_PAD_OE_STATUS, 32'hFFFFFFFF);
      chk("err_ro", {1'b1, 32'h0}, {err, rd});
      apb(1'b0, 12'h014, 32'h0);
      chk("err_rd", {1'b1, 32'h0}, {err, rd});
      pad_in <= 20'hFFFFF;
      // lowest and highest pin of each register, every code
      for (int k = 0; k < 4; k++) begin
         p  = (k / 2) * 10 + (k % 2) * 9;
         sh = 3 * (p % 10);
         a  = (p < 10) ? `GPFS_OFS_SEL_PINS_20_29 : `GPFS_OFS_SEL_PINS_30_39;
         oa = (p < 10) ? `GPFS_OFS_SEL_PINS_30_39 : `GPFS_OFS_SEL_PINS_20_29;
         for (int c = 0; c < 8; c++) begin
            f   = ALT_OF[c];
            // codes 1-7: only the expected source drives high, so a wrong route shows low; code 0: every source drives high
            tmp = (c == 0) ? {6{20'hFFFFF}} : 120'h0;
            if (f >= 0) begin
               tmp[f] = 20'hFFFFF;
            end
            alt_out <= tmp;
            alt_oe  <= tmp;
            gpo     <= (c < 2) ? 20'hFFFFF : 20'h0;
            apb(1'b1, oa, 32'h0);
            apb(1'b1, a, 32'hC0000000 | (32'(c) << sh));
            repeat (8) @(posedge clk_sys_in);
            chk("pad_oe", (c != 0) ? (120'h1 << p) : 120'h0, pad_oe);
            chk("pad_out", (c != 0) ? (120'h1 << p) : 120'h0, pad_out);
            tmp = 120'h0;
            if (f >= 0) begin
               tmp[f][p] = 1'b1;
            end
            chk("alt_in", tmp, alt_in);
            apb(1'b0, a, 32'h0);
            chk("sel_rb", {1'b0, 32'(c) << sh}, {err, rd});
         end
      end
      final_report();
   end
endmodule : tb_gpfs_function_select
